// ---- design/debug_trigger_pkg.sv ----
// Functional notes
// - Debug status, resume PC and scratch: debug mode only.
// - Select and the three data words work in debug and machine mode.
// - The 32-bit select value picks the bank entry the data addresses reach.
// - Select is write_any_read_legal; never keeps an unimplemented index.
// - Data words are views of the selected entry; only the second is full-width read/write.
// - First data word: read-only type in bits 31:28, contents in 27:0.
// - Type 0 means absent, 2 means address/data match, others reserved.
// - Debug-only bit picks the view; debug view only for debug-mode code.
// - Machine access to data words of a debug-only trigger is illegal.
// - Entering debug mode copies the current PC into the resume PC.
// - Leaving debug mode resumes at the stored resume PC.
// - Eight breakpoints per hart, shared by debug and machine mode.
// - First word is match control, second match address, third reserved.
// - Every breakpoint reports type code 2 unless debug-claimed and read from machine mode.
// - Machine mode reads type 0 for a debug-claimed breakpoint.
package debug_trigger_pkg;
	localparam int XLEN = 32;
	localparam int TRIGGER_COUNT = 8;
	localparam int CSR_ADDR_W = 12;
	localparam int CTRL_W = 28;
	// Control register addresses
	localparam logic [CSR_ADDR_W-1:0] ADDR_SELECT = 12'h7a0;
	localparam logic [CSR_ADDR_W-1:0] ADDR_DATA_FIRST = 12'h7a1;
	localparam logic [CSR_ADDR_W-1:0] ADDR_DATA_SECOND = 12'h7a2;
	localparam logic [CSR_ADDR_W-1:0] ADDR_DATA_THIRD = 12'h7a3;
	localparam logic [CSR_ADDR_W-1:0] CSR_DCSR = 12'h7b0;
	localparam logic [CSR_ADDR_W-1:0] CSR_DPC = 12'h7b1;
	localparam logic [CSR_ADDR_W-1:0] CSR_DSCRATCH = 12'h7b2;
	// First data word layout
	localparam int TYPE_LSB = 28;
	localparam logic [3:0] TYPE_NONE = 4'h0;
	localparam logic [3:0] TYPE_MATCH = 4'h2;
	localparam int DMODE_BIT = 27;
	localparam int MASKMAX_LSB = 21;
	localparam int MASKMAX_MSB = 26;
	localparam logic [5:0] MASKMAX_VAL = 6'h04;
	localparam int ACTION_LSB = 12;
	localparam int ACTION_MSB = 17;
	localparam logic [27:0] CTRL_WRITABLE = 28'h0000fdf;
	localparam logic [27:0] CTRL_RESET = 28'h0800000;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
endpackage

// ---- design/debug_trigger_csr_bank.sv ----
`timescale 1ns/100ps
module debug_trigger_csr_bank
	import debug_trigger_pkg::*;
#(
	parameter int TRIGGERS = TRIGGER_COUNT
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control register access from the core
	input wire logic csr_req,
	input wire logic csr_write,
	input wire logic [CSR_ADDR_W-1:0] csr_addr,
	input wire logic [XLEN-1:0] csr_wdata,
	input wire logic in_debug,
	output logic csr_ack,
	output logic [XLEN-1:0] csr_rdata,
	output logic csr_illegal,
	// Debug mode entry and exit
	input wire logic debug_enter,
	input wire logic [XLEN-1:0] current_pc,
	input wire logic debug_exit,
	output logic resume_valid,
	output logic [XLEN-1:0] resume_pc
);
	localparam int SW = (TRIGGERS > 1) ? $clog2(TRIGGERS) : 1;

	// ************************************************************
	// Helpers
	// ************************************************************
	function automatic logic is_trigger_data(
		input logic [CSR_ADDR_W-1:0] a
	);
		return (a == ADDR_DATA_FIRST) || (a == ADDR_DATA_SECOND)
			|| (a == ADDR_DATA_THIRD);
	endfunction

	function automatic logic is_debug_only(input logic [CSR_ADDR_W-1:0] a);
		return (a == CSR_DCSR) || (a == CSR_DPC) || (a == CSR_DSCRATCH);
	endfunction

	// Builds a legal control word from a write
	function automatic logic [CTRL_W-1:0] legal_ctrl(
		input logic [CTRL_W-1:0] old,
		input logic [XLEN-1:0] w,
		input logic dbg
	);
		logic [CTRL_W-1:0] r;
		r = w[CTRL_W-1:0] & CTRL_WRITABLE;
		if (w[ACTION_MSB:ACTION_LSB+1] == '0)
		begin
			r[ACTION_LSB] = w[ACTION_LSB];
		end
		else
		begin
			r[ACTION_LSB] = old[ACTION_LSB];
		end
		r[MASKMAX_MSB:MASKMAX_LSB] = MASKMAX_VAL;
		r[DMODE_BIT] = dbg ? w[DMODE_BIT] : old[DMODE_BIT];
		return r;
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	logic [SW-1:0] sel;
	logic [SW-1:0] next_sel;
	logic [CTRL_W-1:0] ctrl [TRIGGERS];
	logic [CTRL_W-1:0] next_ctrl [TRIGGERS];
	logic [XLEN-1:0] match_addr [TRIGGERS];
	logic [XLEN-1:0] next_match_addr [TRIGGERS];
	logic [XLEN-1:0] dcsr;
	logic [XLEN-1:0] next_dcsr;
	logic [XLEN-1:0] dpc;
	logic [XLEN-1:0] next_dpc;
	logic [XLEN-1:0] dscratch;
	logic [XLEN-1:0] next_dscratch;
	logic next_csr_ack;
	logic [XLEN-1:0] next_csr_rdata;
	logic next_csr_illegal;
	logic next_resume_valid;
	logic [XLEN-1:0] next_resume_pc;
	logic sel_dmode;

	assign sel_dmode = ctrl[sel][DMODE_BIT];

	// ************************************************************
	// Next values
	// ************************************************************
	always_comb
	begin
		next_sel = sel;
		next_ctrl = ctrl;
		next_match_addr = match_addr;
		next_dcsr = dcsr;
		next_dpc = dpc;
		next_dscratch = dscratch;
		next_csr_ack = csr_req;
		next_csr_rdata = WORD_RESET;
		next_csr_illegal = 1'b0;
		next_resume_valid = debug_exit;
		next_resume_pc = resume_pc;
		if (csr_req)
		begin
			if (is_debug_only(csr_addr) && !in_debug)
			begin
				next_csr_illegal = 1'b1;
			end
			else if (is_trigger_data(csr_addr) && !in_debug && sel_dmode)
			begin
				next_csr_illegal = 1'b1;
				next_csr_rdata = {TYPE_NONE, {CTRL_W{1'b0}}};
			end
			else
			begin
				case (csr_addr)
					ADDR_SELECT:
					begin
						next_csr_rdata = XLEN'(sel);
						if (csr_write && (csr_wdata < XLEN'(TRIGGERS)))
						begin
							next_sel = csr_wdata[SW-1:0];
						end
					end
					ADDR_DATA_FIRST:
					begin
						next_csr_rdata = {TYPE_MATCH, ctrl[sel]};
						if (csr_write)
						begin
							// Type nibble of the write is dropped
							next_ctrl[sel] = legal_ctrl(ctrl[sel], csr_wdata,
								in_debug);
						end
					end
					ADDR_DATA_SECOND:
					begin
						next_csr_rdata = match_addr[sel];
						if (csr_write)
						begin
							next_match_addr[sel] = csr_wdata;
						end
					end
					ADDR_DATA_THIRD:
					begin
						next_csr_rdata = WORD_RESET;
					end
					CSR_DCSR:
					begin
						next_csr_rdata = dcsr;
						if (csr_write)
						begin
							next_dcsr = csr_wdata;
						end
					end
					CSR_DPC:
					begin
						next_csr_rdata = dpc;
						if (csr_write)
						begin
							next_dpc = csr_wdata;
						end
					end
					CSR_DSCRATCH:
					begin
						next_csr_rdata = dscratch;
						if (csr_write)
						begin
							next_dscratch = csr_wdata;
						end
					end
					default:
					begin
						next_csr_illegal = 1'b1;
					end
				endcase
			end
		end
		if (debug_enter)
		begin
			next_dpc = current_pc;
		end
		if (debug_exit)
		begin
			next_resume_pc = dpc;
		end
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			sel <= '0;
			dcsr <= WORD_RESET;
			dpc <= WORD_RESET;
			dscratch <= WORD_RESET;
			csr_ack <= 1'b0;
			csr_rdata <= WORD_RESET;
			csr_illegal <= 1'b0;
			resume_valid <= 1'b0;
			resume_pc <= WORD_RESET;
		end
		else
		begin
			sel <= next_sel;
			dcsr <= next_dcsr;
			dpc <= next_dpc;
			dscratch <= next_dscratch;
			csr_ack <= next_csr_ack;
			csr_rdata <= next_csr_rdata;
			csr_illegal <= next_csr_illegal;
			resume_valid <= next_resume_valid;
			resume_pc <= next_resume_pc;
		end
	end

	// Trigger bank, one entry per breakpoint
	for (genvar i = 0; i < TRIGGERS; i++)
	begin : g_bank
		always_ff @(posedge clk or posedge rst)
		begin
			if (rst)
			begin
				ctrl[i] <= CTRL_RESET;
				match_addr[i] <= WORD_RESET;
			end
			else
			begin
				ctrl[i] <= next_ctrl[i];
				match_addr[i] <= next_match_addr[i];
			end
		end
	end

	// ************************************************************
	// Checks
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_debug_only_access: assert property (
		csr_req && !in_debug && is_debug_only(csr_addr)
		|=> csr_ack && csr_illegal && (csr_rdata == WORD_RESET))
		else $error("debug-only register reached outside debug mode");

	a_select_both_modes: assert property (
		csr_req && (csr_addr == ADDR_SELECT)
		|=> csr_ack && !csr_illegal && (csr_rdata == XLEN'($past(sel))))
		else $error("select register access refused or wrong");

	a_select_legal_keep: assert property (
		csr_req && csr_write && (csr_addr == ADDR_SELECT)
		&& (csr_wdata >= XLEN'(TRIGGERS))
		|=> $stable(sel))
		else $error("unimplemented index kept in select");

	a_select_picks_bank: assert property (
		csr_req && csr_write && (csr_addr == ADDR_SELECT)
		&& (csr_wdata < XLEN'(TRIGGERS))
		|=> XLEN'(sel) == $past(csr_wdata))
		else $error("legal select index not taken");

	a_type_code_fixed: assert property (
		csr_req && (csr_addr == ADDR_DATA_FIRST) && (in_debug || !sel_dmode)
		|=> !csr_illegal && (csr_rdata[XLEN-1:TYPE_LSB] == TYPE_MATCH))
		else $error("type code not reported as match trigger");

	a_dmode_blocks_machine: assert property (
		csr_req && !in_debug && sel_dmode && is_trigger_data(csr_addr)
		|=> csr_illegal && (csr_rdata == WORD_RESET) && $stable(ctrl[sel]))
		else $error("machine access to debug-only trigger not refused");

	a_machine_no_dmode: assert property (
		csr_req && csr_write && !in_debug && !sel_dmode
		&& (csr_addr == ADDR_DATA_FIRST)
		|=> !sel_dmode)
		else $error("machine mode claimed a trigger for debug");

	a_addr_write_lands: assert property (
		csr_req && csr_write && (csr_addr == ADDR_DATA_SECOND)
		&& (in_debug || !sel_dmode)
		|=> match_addr[sel] == $past(csr_wdata))
		else $error("match address write lost");

	a_pc_captured: assert property (
		debug_enter |=> dpc == $past(current_pc))
		else $error("resume PC not captured on debug entry");

	a_resume_at_pc: assert property (
		debug_exit |=> resume_valid && (resume_pc == $past(dpc)))
		else $error("resume not at stored PC");

	c_debug_round_trip: cover property (debug_enter ##[1:20] debug_exit);
	c_dmode_refused: cover property (
		csr_req && !in_debug && sel_dmode && is_trigger_data(csr_addr));
	c_select_last: cover property (
		csr_req && csr_write && (csr_addr == ADDR_SELECT)
		&& (csr_wdata == XLEN'(TRIGGERS - 1)));
	c_bad_select: cover property (
		csr_req && csr_write && (csr_addr == ADDR_SELECT)
		&& (csr_wdata >= XLEN'(TRIGGERS)));

endmodule // debug_trigger_csr_bank

// ---- tb/core_model.sv ----
`timescale 1ns/100ps
module core_model
	import debug_trigger_pkg::*;
(
	// Clock
	input wire logic clk,
	// Requests to the block
	output logic csr_req,
	output logic csr_write,
	output logic [CSR_ADDR_W-1:0] csr_addr,
	output logic [XLEN-1:0] csr_wdata,
	output logic in_debug,
	output logic debug_enter,
	output logic [XLEN-1:0] current_pc,
	output logic debug_exit,
	// Answers from the block
	input wire logic csr_ack,
	input wire logic [XLEN-1:0] csr_rdata,
	input wire logic csr_illegal
);
	// ****************
	// Core side
	// ****************
	initial
	begin
		csr_req = 1'b0;
		csr_write = 1'b0;
		csr_addr = 12'h000;
		csr_wdata = 32'h00000000;
		in_debug = 1'b0;
		debug_enter = 1'b0;
		current_pc = 32'h00000000;
		debug_exit = 1'b0;
	end
	// One-cycle request; answer taken while the acknowledge stands
	task automatic access(input logic dbg, w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rd, output logic il, ok);
		@(posedge clk);
		#1;
		in_debug = dbg;
		csr_req = 1'b1;
		csr_write = w;
		csr_addr = a;
		csr_wdata = d;
		@(posedge clk);
		#1;
		csr_req = 1'b0;
		csr_wdata = ~d;
		ok = (csr_ack === 1'b1);
		rd = csr_rdata;
		il = csr_illegal;
	endtask
	// Entry or exit pulse with the current PC
	task automatic debug_step(input logic en, ex, input logic [31:0] pc);
		@(posedge clk);
		#1;
		debug_enter = en;
		debug_exit = ex;
		current_pc = pc;
		@(posedge clk);
		#1;
		debug_enter = 1'b0;
		debug_exit = 1'b0;
		current_pc = ~pc;
	endtask
endmodule // core_model

// ---- tb/debug_trigger_csr_bank_tb.sv ----
`timescale 1ns/100ps
module debug_trigger_csr_bank_tb;
	import debug_trigger_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic csr_req, csr_write, in_debug, debug_enter, debug_exit;
	logic csr_ack, csr_illegal, resume_valid;
	logic [11:0] csr_addr;
	logic [31:0] csr_wdata, current_pc, csr_rdata, resume_pc;
	int err_total = 0;
	int n_compared = 0;
	always #4 clk = ~clk;
	debug_trigger_csr_bank debug_trigger_csr_bank_i (.clk(clk), .rst(rst),
		.csr_req(csr_req), .csr_write(csr_write), .csr_addr(csr_addr),
		.csr_wdata(csr_wdata), .in_debug(in_debug), .csr_ack(csr_ack),
		.csr_rdata(csr_rdata), .csr_illegal(csr_illegal),
		.debug_enter(debug_enter), .current_pc(current_pc),
		.debug_exit(debug_exit), .resume_valid(resume_valid),
		.resume_pc(resume_pc));
	core_model core_model_i (.clk(clk), .csr_req(csr_req),
		.csr_write(csr_write), .csr_addr(csr_addr), .csr_wdata(csr_wdata),
		.in_debug(in_debug), .debug_enter(debug_enter),
		.current_pc(current_pc), .debug_exit(debug_exit), .csr_ack(csr_ack),
		.csr_rdata(csr_rdata), .csr_illegal(csr_illegal));
	// ****************
	// Checks
	// ****************
	task automatic check(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic go(input logic dbg, w, input logic [11:0] a,
		input logic [31:0] d, e, input logic ie);
		logic [31:0] rd;
		logic il, ok;
		core_model_i.access(dbg, w, a, d, rd, il, ok);
		check("ack", {31'h0, ok}, 32'h1);
		check("illegal", {31'h0, il}, {31'h0, ie});
		if (!w)
			check("rdata", rd, e);
	endtask
	task automatic stop_test;
		$display("Mismatches %0d of %0d checks", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge clk);
		err_total++;
		stop_test;
	end
	// ****************
	// Scenarios
	// ****************
	initial
	begin
		repeat (20) @(posedge clk);
		#1;
		rst = 1'b0;
		go(1, 0, ADDR_DATA_FIRST, 0, 32'h20800000, 0);
		for (int i = 0; i < 8; i++)
		begin
			go(0, 1, ADDR_SELECT, i, 0, 0);
			go(0, 0, ADDR_DATA_FIRST, 0, 32'h20800000, 0);
			go(0, 1, ADDR_DATA_SECOND, 32'h11111111 * i, 0, 0);
		end
		go(0, 1, ADDR_SELECT, 8, 0, 0);
		go(0, 0, ADDR_SELECT, 0, 7, 0);
		for (int i = 0; i < 8; i++)
		begin
			go(0, 1, ADDR_SELECT, i, 0, 0);
			go(0, 0, ADDR_DATA_SECOND, 0, 32'h11111111 * i, 0);
		end
		go(0, 1, ADDR_DATA_THIRD, 32'hffffffff, 0, 0);
		go(0, 0, ADDR_DATA_THIRD, 0, 0, 0);
		go(0, 1, ADDR_SELECT, 2, 0, 0);
		go(0, 1, ADDR_DATA_FIRST, 32'hf0000fdf, 0, 0);
		go(0, 0, ADDR_DATA_FIRST, 0, 32'h20800fdf, 0);
		go(1, 1, ADDR_DATA_FIRST, 32'h08000000, 0, 0);
		go(1, 0, ADDR_DATA_FIRST, 0, 32'h28800000, 0);
		go(0, 0, ADDR_DATA_FIRST, 0, 0, 1);
		go(0, 1, ADDR_DATA_SECOND, 5, 0, 1);
		go(1, 0, ADDR_DATA_SECOND, 0, 32'h22222222, 0);
		go(1, 1, ADDR_DATA_FIRST, 0, 0, 0);
		go(0, 0, ADDR_DATA_FIRST, 0, 32'h20800000, 0);
		go(0, 1, ADDR_DATA_FIRST, 32'h00001000, 0, 0);
		go(0, 0, ADDR_DATA_FIRST, 0, 32'h20801000, 0);
		go(0, 1, ADDR_DATA_FIRST, 32'h00002000, 0, 0);
		go(0, 0, ADDR_DATA_FIRST, 0, 32'h20801000, 0);
		go(0, 0, CSR_DCSR, 0, 0, 1);
		go(0, 1, CSR_DPC, 1, 0, 1);
		go(1, 0, CSR_DPC, 0, 0, 0);
		go(0, 0, CSR_DSCRATCH, 0, 0, 1);
		go(1, 1, CSR_DCSR, 32'h00000403, 0, 0);
		go(1, 0, CSR_DCSR, 0, 32'h00000403, 0);
		go(1, 1, CSR_DSCRATCH, 32'h5a5a0f0f, 0, 0);
		go(1, 0, CSR_DSCRATCH, 0, 32'h5a5a0f0f, 0);
		go(1, 0, 12'h7c0, 0, 0, 1);
		core_model_i.debug_step(1, 0, 32'h80000124);
		go(1, 0, CSR_DPC, 0, 32'h80000124, 0);
		core_model_i.debug_step(0, 1, 0);
		check("resume_valid", {31'h0, resume_valid}, 1);
		check("resume_pc", resume_pc, 32'h80000124);
		stop_test;
	end
endmodule // debug_trigger_csr_bank_tb
